/* dbx_pkg.sv */
// Package for the doubleword bit-field extract datapath: encodings, field positions, reset values
package dbx_pkg;

  // Instruction field positions
  localparam int DBX_OPC_HI = 31;
  localparam int DBX_OPC_LO = 26;
  localparam int DBX_SRC_HI = 25;
  localparam int DBX_SRC_LO = 21;
  localparam int DBX_TGT_HI = 20;
  localparam int DBX_TGT_LO = 16;
  localparam int DBX_TOP_HI = 15;
  localparam int DBX_TOP_LO = 11;
  localparam int DBX_BOT_HI = 10;
  localparam int DBX_BOT_LO = 6;
  localparam int DBX_FN_HI = 5;
  localparam int DBX_FN_LO = 0;

  // Encodings
  localparam logic [5:0] DBX_OPC_THIRD_SPECIAL = 6'h1f;
  localparam logic [5:0] DBX_FN_LOW_WORD = 6'h03;
  localparam logic [5:0] DBX_FN_WIDE = 6'h01;
  localparam logic [5:0] DBX_FN_UPPER_WORD = 6'h02;

  // Field arithmetic
  localparam logic [5:0] DBX_FIELD_OFFSET = 6'h20;
  localparam logic [5:0] DBX_FIELD_TOP_MAX = 6'h3f;
  localparam logic [6:0] DBX_WIDE_LIMIT = 7'h40;

  // Lowest architecture revision that executes the extract family
  localparam logic [2:0] DBX_MIN_REV = 3'h2;

  // Values after reset
  localparam logic [63:0] DBX_DATA_RESET = 64'h0;
  localparam logic [4:0] DBX_INDEX_RESET = 5'h0;

  typedef enum logic [1:0] {
    DBX_VAR_NONE,
    DBX_VAR_LOW,
    DBX_VAR_WIDE,
    DBX_VAR_UPPER
  } dbx_variant_t;

endpackage : dbx_pkg

/* dbx_field_unit.sv */
// Shift-and-mask unit: right-justified, zero-extended field of a 64-bit word
`timescale 1ns/100ps
`default_nettype none
module dbx_field_unit (
  // Operand
  input wire logic [63:0] src,
  // Effective field bottom and top (top counts from the bottom)
  input wire logic [5:0] bottom,
  input wire logic [5:0] top,
  // Result
  output logic [63:0] field
);
  import dbx_pkg::*;

  logic [63:0] shifted;
  logic [63:0] mask;

  always_comb begin
    shifted = src >> bottom;
    // A top of 63 keeps the whole word, so the mask never needs a 65th bit
    mask = {64{1'b1}} >> (DBX_FIELD_TOP_MAX - top);
    field = shifted & mask;
  end

endmodule : dbx_field_unit
`default_nettype wire

/* dbx_extract.sv */
// Doubleword bit-field extract datapath: decode, field select and write-back stage
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Decode major opcode 011111; function 000011 low-word, 000001 wide variant.
// - Field top comes from bits 15..11, field bottom from bits 10..6.
// - Copy source bits bottom..bottom+top to result LSBs, zero above.
// - Low-word variant: top and bottom 0..31, every encoding defined.
// - Wide variant adds 32 to the encoded field top.
// - Wide variant with bottom+top+1 above 64 may write any value.
// - Function 000010 is upper-word variant; add 32 to encoded field bottom.
// - Upper-word variant covers starts 32..63, sizes 1..32.
// - Wide variant covers sizes 33..64 starting at bits 0..31.
// - Cores before revision 2 raise Reserved Instruction instead of executing.
module dbx_extract (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Issue from the decoder
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [63:0] issue_source_data,
  // Core configuration
  input wire logic [2:0] core_arch_rev,
  // Claim of the current issue slot
  output logic extract_hit,
  // Write-back to the general register file
  output logic wb_valid,
  output logic [4:0] wb_target_index,
  output logic [63:0] wb_data,
  output logic wb_unpredictable,
  // Exception report
  output logic resv_instr_exc
);
  import dbx_pkg::*;

  dbx_variant_t variant;
  logic [5:0] enc_top;
  logic [5:0] enc_bottom;
  logic [5:0] eff_top;
  logic [5:0] eff_bottom;
  logic [6:0] wide_span;
  logic rev_ok;
  logic [63:0] field;

  logic wb_valid_reg;
  logic wb_valid_next;
  logic [4:0] wb_index_reg;
  logic [4:0] wb_index_next;
  logic [63:0] wb_data_reg;
  logic [63:0] wb_data_next;
  logic unpred_reg;
  logic unpred_next;
  logic exc_reg;
  logic exc_next;

  // Decode and effective field bounds
  always_comb begin
    variant = DBX_VAR_NONE;
    enc_top = {1'b0, issue_instr[DBX_TOP_HI:DBX_TOP_LO]};
    enc_bottom = {1'b0, issue_instr[DBX_BOT_HI:DBX_BOT_LO]};
    eff_top = enc_top;
    eff_bottom = enc_bottom;
    if (issue_instr[DBX_OPC_HI:DBX_OPC_LO] == DBX_OPC_THIRD_SPECIAL) begin
      if (issue_instr[DBX_FN_HI:DBX_FN_LO] == DBX_FN_LOW_WORD) begin
        variant = DBX_VAR_LOW;
      end else if (issue_instr[DBX_FN_HI:DBX_FN_LO] == DBX_FN_WIDE) begin
        variant = DBX_VAR_WIDE;
      end else if (issue_instr[DBX_FN_HI:DBX_FN_LO] == DBX_FN_UPPER_WORD) begin
        variant = DBX_VAR_UPPER;
      end
    end
    // Offsets ride in bit 5, so the sum never carries out of six bits
    if (variant == DBX_VAR_WIDE) begin
      eff_top = enc_top + DBX_FIELD_OFFSET;
    end
    if (variant == DBX_VAR_UPPER) begin
      eff_bottom = enc_bottom + DBX_FIELD_OFFSET;
    end
    wide_span = 7'({1'b0, eff_bottom} + {1'b0, eff_top} + 7'h1);
    rev_ok = (core_arch_rev >= DBX_MIN_REV);
    extract_hit = issue_valid && (variant != DBX_VAR_NONE);
  end

  dbx_field_unit u_field (
    .src(issue_source_data),
    .bottom(eff_bottom),
    .top(eff_top),
    .field(field)
  );

  // Write-back stage next values
  always_comb begin
    wb_valid_next = extract_hit && rev_ok;
    exc_next = extract_hit && !rev_ok;
    wb_index_next = wb_index_reg;
    wb_data_next = wb_data_reg;
    unpred_next = 1'b0;
    if (wb_valid_next) begin
      wb_index_next = issue_instr[DBX_TGT_HI:DBX_TGT_LO];
      // The upper-word span can reach 95, past 64; source bits beyond bit 63 shift in as zero
      wb_data_next = field;
      unpred_next = (variant == DBX_VAR_WIDE) && (wide_span > DBX_WIDE_LIMIT);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_valid_reg <= 1'b0;
      wb_index_reg <= DBX_INDEX_RESET;
      wb_data_reg <= DBX_DATA_RESET;
      unpred_reg <= 1'b0;
      exc_reg <= 1'b0;
    end else begin
      wb_valid_reg <= wb_valid_next;
      wb_index_reg <= wb_index_next;
      wb_data_reg <= wb_data_next;
      unpred_reg <= unpred_next;
      exc_reg <= exc_next;
    end
  end

  assign wb_valid = wb_valid_reg;
  assign wb_target_index = wb_index_reg;
  assign wb_data = wb_data_reg;
  assign wb_unpredictable = unpred_reg;
  assign resv_instr_exc = exc_reg;

  // Checks: a bit-serial model, independent of the shift-and-mask unit

  function automatic logic [63:0] ref_extract(input logic [63:0] s, input int bot, input int top);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 64; i++) begin
      if (i <= top && (bot + i) < 64) begin
        r[i] = s[bot + i];
      end
    end
    return r;
  endfunction : ref_extract

  function automatic logic [63:0] top_mask(input int top);
    logic [63:0] m;
    m = 64'h0;
    for (int i = 0; i < 64; i++) begin
      if (i <= top) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : top_mask

  logic [5:0] chk_top_reg;
  logic [5:0] chk_top_next;

  always_comb begin
    chk_top_next = wb_valid_next ? eff_top : chk_top_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chk_top_reg <= 6'h0;
    end else begin
      chk_top_reg <= chk_top_next;
    end
  end

  default clocking dbx_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_ext_issue(logic [5:0] fn);
    issue_valid && issue_instr[31:26] == 6'h1f && issue_instr[5:0] == fn;
  endsequence

  sequence s_rev_new;
    core_arch_rev >= 3'h2;
  endsequence

  sequence s_rev_old;
    core_arch_rev < 3'h2;
  endsequence

  property p_issue_writes(logic [5:0] fn);
    (s_ext_issue(fn) and s_rev_new) |=> wb_valid && !resv_instr_exc
      ##1 !wb_valid || $past(issue_valid);
  endproperty

  a_decode_low: assert property (p_issue_writes(6'h03))
    else $error("low-word extract issue did not write back");

  a_decode_wide: assert property (p_issue_writes(6'h01))
    else $error("wide extract issue did not write back");

  a_target_index: assert property ((s_ext_issue(6'h03) and s_rev_new)
    |=> wb_target_index == $past(issue_instr[20:16]))
    else $error("write-back target index does not match instruction");

  a_low_result: assert property ((s_ext_issue(6'h03) and s_rev_new)
    |=> wb_data == ref_extract($past(issue_source_data),
      int'($past(issue_instr[10:6])), int'($past(issue_instr[15:11]))))
    else $error("low-word extract result wrong");

  a_zero_fill: assert property (wb_valid |-> (wb_data & ~top_mask(int'(chk_top_reg))) == 64'h0)
    else $error("bits above the field are not zero");

  a_wide_top: assert property ((s_ext_issue(6'h01) and s_rev_new)
    ##1 !wb_unpredictable |-> wb_data == ref_extract($past(issue_source_data),
      int'($past(issue_instr[10:6])), int'($past(issue_instr[15:11])) + 32))
    else $error("wide extract result wrong");

  a_wide_unpred: assert property ((s_ext_issue(6'h01) and s_rev_new)
    |=> wb_unpredictable == (int'($past(issue_instr[10:6]))
      + int'($past(issue_instr[15:11])) + 33 > 64))
    else $error("unpredictable flag wrong for wide extract");

  a_upper_bottom: assert property ((s_ext_issue(6'h02) and s_rev_new)
    |=> wb_valid && !wb_unpredictable && wb_data == ref_extract($past(issue_source_data),
      int'($past(issue_instr[10:6])) + 32, int'($past(issue_instr[15:11]))))
    else $error("upper-word extract result wrong");

  a_old_rev_exc: assert property ((s_ext_issue(6'h02) and s_rev_old)
    |=> resv_instr_exc && !wb_valid)
    else $error("older revision did not raise reserved instruction");

  a_exc_no_write: assert property (resv_instr_exc |-> !wb_valid
    && $stable(wb_data) && $stable(wb_target_index))
    else $error("target written alongside an exception");

  a_wb_one_cycle: assert property (wb_valid |-> $past(extract_hit) && $past(issue_valid))
    else $error("write-back without an extract issue one cycle earlier");

  // Further checks: field ends, variant ranges and exception causes

  // Single-bit lookup at a run-time position; positions past bit 63 read as zero
  function automatic logic bit_at(input logic [63:0] s, input int idx);
    logic v;
    v = 1'b0;
    if (idx >= 0 && idx < 64) begin
      v = s[idx];
    end
    return v;
  endfunction : bit_at

  a_hit_decode: assert property (extract_hit == (issue_valid
    && issue_instr[31:26] == 6'h1f && issue_instr[5:0] inside {6'h01, 6'h02, 6'h03}))
    else $error("slot claim does not match the issued instruction");

  a_other_ignored: assert property (!(issue_valid && issue_instr[31:26] == 6'h1f
    && issue_instr[5:0] inside {6'h01, 6'h02, 6'h03}) |=> !wb_valid && !resv_instr_exc)
    else $error("an issue outside the extract family produced an output");

  a_field_bottom: assert property ((s_ext_issue(6'h03) and s_rev_new) |=> wb_data[0]
    == bit_at($past(issue_source_data), int'($past(issue_instr[10:6]))))
    else $error("low-word result does not start at the field bottom");

  a_field_top: assert property ((s_ext_issue(6'h03) and s_rev_new)
    |=> bit_at(wb_data, int'($past(issue_instr[15:11]))) == bit_at($past(issue_source_data),
      int'($past(issue_instr[10:6])) + int'($past(issue_instr[15:11]))))
    else $error("low-word result does not end at the field top");

  a_low_defined: assert property ((s_ext_issue(6'h03) and s_rev_new)
    |=> wb_valid && !wb_unpredictable)
    else $error("low-word extract flagged as unpredictable");

  a_wide_bottom: assert property ((s_ext_issue(6'h01) and s_rev_new)
    |=> wb_unpredictable || wb_data[0] == bit_at($past(issue_source_data),
      int'($past(issue_instr[10:6]))))
    else $error("wide result does not start at the field bottom");

  // Bit 32 lies inside the field only when the field is longer than one word
  a_wide_long: assert property ((s_ext_issue(6'h01) and s_rev_new) ##1 !wb_unpredictable
    |-> wb_data[32] == bit_at($past(issue_source_data), int'($past(issue_instr[10:6])) + 32))
    else $error("wide extract lost the bits above the lower word");

  a_unpred_wide: assert property (wb_unpredictable |-> wb_valid
    && $past(issue_instr[5:0]) == 6'h01)
    else $error("unpredictable flag raised outside the wide variant");

  // Upper-word fields may only draw on source bits 32 and up
  a_upper_word: assert property ((s_ext_issue(6'h02) and s_rev_new)
    |=> wb_data == ref_extract({32'h0, $past(issue_source_data[63:32])},
      int'($past(issue_instr[10:6])), int'($past(issue_instr[15:11]))))
    else $error("upper-word extract reached into the lower word");

  // Every variant must trap on an older core, not only the upper-word one
  a_low_old_exc: assert property ((s_ext_issue(6'h03) and s_rev_old)
    |=> resv_instr_exc && !wb_valid)
    else $error("older revision executed a low-word extract");

  a_wide_old_exc: assert property ((s_ext_issue(6'h01) and s_rev_old)
    |=> resv_instr_exc && !wb_valid)
    else $error("older revision executed a wide extract");

  a_exc_cause: assert property (resv_instr_exc |-> $past(extract_hit)
    && $past(core_arch_rev) < 3'h2)
    else $error("reserved instruction raised without an older-revision extract");

  a_exc_clean: assert property (resv_instr_exc |-> !wb_unpredictable)
    else $error("unpredictable flag raised alongside an exception");

  a_target_any: assert property (wb_valid
    |-> wb_target_index == $past(issue_instr[20:16]))
    else $error("write-back target differs from the issued instruction");

endmodule : dbx_extract
`default_nettype wire

/* dbx_gpr_model.sv */
// General register file model behind the extract datapath
`timescale 1ns/100ps
`default_nettype none
module dbx_gpr_model (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic [4:0] rd_index,
  output logic [63:0] rd_data,
  // Write-back port
  input wire logic wb_valid,
  input wire logic [4:0] wb_target_index,
  input wire logic [63:0] wb_data
);
  logic [63:0] regs [32];
  // Distinct patterns per register so a wrong source or shift shows
  initial begin
    for (int i = 0; i < 32; i++) begin
      regs[i] = {32'h8badf00d ^ (32'h01010101 * i), 32'hc3a55a3c + i};
    end
  end
  assign rd_data = regs[rd_index];
  always @(posedge clk) begin
    if (wb_valid) begin
      regs[wb_target_index] <= wb_data;
    end
  end
endmodule : dbx_gpr_model
`default_nettype wire

/* doubleword_bitfield_extract_tb_top.sv */
// Self-checking testbench of the doubleword bit-field extract datapath
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
  $display("Error %0t %s", $time, m); miscompares++; end end
module doubleword_bitfield_extract_tb_top;
  import dbx_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, issue_valid = 1'b0, known = 1'b1;
  logic [31:0] issue_instr = 32'h0;
  logic [2:0] core_arch_rev = 3'h2;
  logic extract_hit, wb_valid, wb_unpredictable, resv_instr_exc;
  logic [4:0] wb_target_index;
  logic [63:0] wb_data, src_data, last_data = 64'h0;
  logic [4:0] last_tgt = 5'h0;
  int miscompares = 0, check_count = 0;
  dbx_extract dbx_extract_i (.clk(clk), .rstn(rstn), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .issue_source_data(src_data), .core_arch_rev(core_arch_rev),
    .extract_hit(extract_hit), .wb_valid(wb_valid), .wb_target_index(wb_target_index),
    .wb_data(wb_data), .wb_unpredictable(wb_unpredictable), .resv_instr_exc(resv_instr_exc));
  dbx_gpr_model dbx_gpr_model_i (.clk(clk), .rd_index(issue_instr[25:21]), .rd_data(src_data),
    .wb_valid(wb_valid), .wb_target_index(wb_target_index), .wb_data(wb_data));
  initial begin
    forever #25 clk = ~clk;
  end
  // One issue; the next call may follow at once for back-to-back traffic
  task automatic run(input logic [5:0] opc, input logic [5:0] fn, input logic [4:0] top,
      input logic [4:0] bot, input logic [4:0] src, input logic [4:0] tgt);
    logic hit, exe, unp;
    logic [6:0] b, t;
    logic [63:0] exp;
    hit = (opc == 6'h1f) && (fn == 6'h03 || fn == 6'h01 || fn == 6'h02);
    exe = hit && (core_arch_rev >= 3'h2);
    b = {2'h0, bot} + ((fn == 6'h02) ? 7'h20 : 7'h00);
    t = {2'h0, top} + ((fn == 6'h01) ? 7'h20 : 7'h00);
    unp = (fn == 6'h01) && ((b + t + 7'h01) > 7'h40);
    issue_valid = 1'b1;
    issue_instr = {opc, src, tgt, top, bot, fn};
    #1;
    exp = (src_data >> b) & ((t == 7'h3f) ? '1 : ((64'h1 << (t + 7'h01)) - 64'h1));
    `CHK(extract_hit, hit, "slot claim")
    @(posedge clk);
    #1;
    `CHK(wb_valid, exe, "write-back strobe")
    `CHK(resv_instr_exc, hit && !exe, "reserved instruction")
    if (exe) begin
      `CHK(wb_target_index, tgt, "target index")
      `CHK(wb_unpredictable, unp, "unpredictable flag")
      if (!unp) begin
        `CHK(wb_data, exp, "extracted field")
      end
      last_data = exp;
      last_tgt = tgt;
      known = !unp;
    end else begin
      `CHK(wb_target_index, last_tgt, "target held")
      if (known) begin
        `CHK(wb_data, last_data, "data held")
      end
    end
  endtask : run
  task automatic idle;
    issue_valid = 1'b0;
    #1;
    `CHK(extract_hit, 1'b0, "no claim when idle")
    @(posedge clk);
    #1;
    `CHK(wb_valid | resv_instr_exc, 1'b0, "no output when idle")
  endtask : idle
  task automatic t_low;
    for (int k = 0; k < 4; k++) begin
      run(6'h1f, 6'h03, {5{k[0]}}, {5{k[1]}}, 5'(k + 1), 5'(k + 9));
    end
    run(6'h1f, 6'h03, 5'h0a, 5'h05, 5'h07, 5'h14);
  endtask : t_low
  // Full 64-bit field, 33-bit field at bit 31, 38-bit field at bit 3, then two past the top
  task automatic t_wide;
    run(6'h1f, 6'h01, 5'h1f, 5'h00, 5'h03, 5'h15);
    run(6'h1f, 6'h01, 5'h00, 5'h1f, 5'h04, 5'h16);
    run(6'h1f, 6'h01, 5'h05, 5'h03, 5'h05, 5'h17);
    run(6'h1f, 6'h01, 5'h1f, 5'h01, 5'h06, 5'h18);
    run(6'h1f, 6'h01, 5'h14, 5'h14, 5'h07, 5'h19);
  endtask : t_wide
  task automatic t_upper;
    run(6'h1f, 6'h02, 5'h00, 5'h1f, 5'h08, 5'h1a);
    run(6'h1f, 6'h02, 5'h1f, 5'h00, 5'h09, 5'h1b);
    run(6'h1f, 6'h02, 5'h03, 5'h09, 5'h0a, 5'h1c);
  endtask : t_upper
  // Insert-middle function and a foreign opcode must both pass by
  task automatic t_ignore;
    run(6'h1f, 6'h05, 5'h03, 5'h02, 5'h0b, 5'h1d);
    run(6'h00, 6'h03, 5'h03, 5'h02, 5'h0c, 5'h1e);
    idle();
  endtask : t_ignore
  task automatic t_rev;
    core_arch_rev = 3'h1;
    run(6'h1f, 6'h03, 5'h04, 5'h02, 5'h0d, 5'h01);
    run(6'h1f, 6'h01, 5'h04, 5'h02, 5'h0e, 5'h02);
    core_arch_rev = 3'h0;
    run(6'h1f, 6'h02, 5'h04, 5'h02, 5'h0f, 5'h03);
    core_arch_rev = 3'h2;
    run(6'h1f, 6'h03, 5'h1f, 5'h00, 5'h10, 5'h04);
    idle();
  endtask : t_rev
  task automatic results;
    $display("Compares %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    #(500 * 50);
    miscompares++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    `CHK(wb_data, 64'h0, "reset data")
    `CHK({wb_valid, resv_instr_exc, wb_unpredictable, wb_target_index}, 8'h0, "reset flags")
    t_low();
    t_wide();
    t_upper();
    t_ignore();
    t_rev();
    results();
  end
endmodule : doubleword_bitfield_extract_tb_top
`default_nettype wire
